// [common/eiu_map.vh]
// Purpose: register map, field layout, reset values and timing counts of the
//          external interrupt unit
// Assumes: 32-bit axi4-lite data, byte addresses, one register per word
// Notes:   definitions only
`ifndef EIU_MAP_VH
`define EIU_MAP_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define EIU_OFS_SENSE_CTRL   8'h00
`define EIU_OFS_DED_MASK     8'h04
`define EIU_OFS_DED_FLAGS    8'h08
`define EIU_OFS_GRP_ENABLE   8'h0c
`define EIU_OFS_GRP_FLAGS    8'h10
`define EIU_OFS_CHG_MASK0    8'h14
`define EIU_OFS_CHG_MASK1    8'h18
`define EIU_OFS_CHG_MASK2    8'h1c
`define EIU_OFS_CHG_MASK3    8'h20
`define EIU_OFS_GLOBAL_CTRL  8'h24
`define EIU_OFS_PIN_STATUS   8'h28

// ****************************************************************
// fields and reset values
// ****************************************************************
`define EIU_SENSE_USED_W     6
`define EIU_GIE_BIT          0
`define EIU_SENSE_RST        6'h00
`define EIU_DED_MASK_RST     3'h0
`define EIU_GRP_ENABLE_RST   4'h0
`define EIU_CHG_MASK_RST     8'h00
`define EIU_GIE_RST          1'b0

// ****************************************************************
// sense field encodings
// ****************************************************************
`define EIU_SENSE_LOW        2'b00
`define EIU_SENSE_ANY        2'b01
`define EIU_SENSE_FALL       2'b10
`define EIU_SENSE_RISE       2'b11

// ****************************************************************
// axi responses
// ****************************************************************
`define EIU_RESP_OKAY        2'b00
`define EIU_RESP_SLVERR      2'b10

// ****************************************************************
// timing
// ****************************************************************
`define EIU_CLK_PERIOD_NS    10
`define EIU_STARTUP_NS       1000
`define EIU_STARTUP_CYC      ((`EIU_STARTUP_NS + `EIU_CLK_PERIOD_NS - 1) / `EIU_CLK_PERIOD_NS)

`endif

// [core/eiu_top.v]
// Purpose: external interrupt unit: three dedicated lines, 32 pin-change inputs
// Assumes: clk_sys_i is the always-on clock; io clock gating is outside
// Notes:   registers over axi4-lite, requests to the core are registered
//
// Operation
// - pins interrupt even when driven as outputs
// - group n fires on enabled toggle in byte n
// - four change masks gate group contributions
// - pin changes detected without io clock
// - dedicated lines: low level, any change, falling or rising
// - level mode requests while pin stays low
// - dedicated detection works without io clock
// - io clock stops outside idle sleep
// - level gone before start-up: wake, no interrupt
// - sense register bits 7:6 read zero
// - two sense bits per dedicated line
// - needs global enable and line mask bit
// - pulses above minimum width are caught
//
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "eiu_map.vh"
`default_nettype none

module eiu_top #(
    parameter        ADDR_W      = 8,
    parameter [15:0] STARTUP_CYC = `EIU_STARTUP_CYC
) (
    input  wire              clk_sys_i,
    input  wire              rst_i,
    input  wire [ADDR_W-1:0] s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output reg               s_axi_awready,
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output reg               s_axi_wready,
    output reg  [1:0]        s_axi_bresp,
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    input  wire [ADDR_W-1:0] s_axi_araddr,
    input  wire              s_axi_arvalid,
    output reg               s_axi_arready,
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready,
    input  wire [2:0]        dedicated_irq_pins_i,
    input  wire [31:0]       pin_change_inputs_i,
    input  wire              sleep_i,
    input  wire [2:0]        ded_ack_i,
    input  wire [3:0]        grp_ack_i,
    output reg  [2:0]        dedicated_irq_o,
    output reg  [3:0]        change_group_irq_o,
    output reg               wake_o
);

    // ****************************************************************
    // functions
    // ****************************************************************
    function edge_hit;
        input [1:0] mode;
        input       now;
        input       was;
        begin
            case (mode)
                `EIU_SENSE_ANY:  edge_hit = now ^ was;
                `EIU_SENSE_FALL: edge_hit = was & ~now;
                `EIU_SENSE_RISE: edge_hit = now & ~was;
                default:         edge_hit = 1'b0;
            endcase
        end
    endfunction

    function addr_is;
        input [ADDR_W-1:0] addr;
        input [7:0]        ofs;
        begin
            addr_is = (addr[7:2] == ofs[7:2]);
        end
    endfunction

    // ****************************************************************
    // registers
    // ****************************************************************
    reg [5:0]        ext_int_sense_control_reg;
    reg [2:0]        dedicated_irq_mask_reg;
    reg [2:0]        ded_flags_reg;
    reg [3:0]        grp_enable_reg;
    reg [3:0]        grp_flags_reg;
    reg [31:0]       change_mask_reg;
    reg              global_irq_enable_reg;
    reg [15:0]       startup_cnt_reg;
    reg              sleep_d_reg;

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    // the pad buffer feeds these inputs whatever the pin direction, so
    // software driving a pin as output still triggers its interrupt
    reg [2:0]        ded_s1_reg;
    reg [2:0]        ded_s2_reg;
    reg [2:0]        ded_prev_reg;
    reg [31:0]       chg_s1_reg;
    reg [31:0]       chg_s2_reg;
    reg [31:0]       chg_prev_reg;

    // detection runs on the always-on clock, never on the gated io clock,
    // so it keeps working in every sleep mode
    // a pulse is seen once it spans one clock edge; shorter ones may be
    // missed, which sets the minimum pulse width
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            ded_s1_reg   <= 3'h7;
            ded_s2_reg   <= 3'h7;
            ded_prev_reg <= 3'h7;
            chg_s1_reg   <= 32'h0000_0000;
            chg_s2_reg   <= 32'h0000_0000;
            chg_prev_reg <= 32'h0000_0000;
        end else begin
            ded_s1_reg   <= dedicated_irq_pins_i;
            ded_s2_reg   <= ded_s1_reg;
            ded_prev_reg <= ded_s2_reg;
            chg_s1_reg   <= pin_change_inputs_i;
            chg_s2_reg   <= chg_s1_reg;
            chg_prev_reg <= chg_s2_reg;
        end
    end

    // ****************************************************************
    // event detection
    // ****************************************************************
    reg [2:0]  ded_edge;
    reg [2:0]  ded_level;
    reg [3:0]  grp_hit;
    reg [31:0] chg_toggle;
    integer    i;

    always @* begin
        chg_toggle = (chg_s2_reg ^ chg_prev_reg) & change_mask_reg;
        for (i = 0; i < 3; i = i + 1) begin
            ded_edge[i] = edge_hit(ext_int_sense_control_reg[2*i +: 2],
                                   ded_s2_reg[i], ded_prev_reg[i]);
            ded_level[i] = (ext_int_sense_control_reg[2*i +: 2] == `EIU_SENSE_LOW) &
                           ~ded_s2_reg[i];
        end
        for (i = 0; i < 4; i = i + 1) begin
            grp_hit[i] = |chg_toggle[8*i +: 8];
        end
    end

    // ****************************************************************
    // axi4-lite write channel
    // ****************************************************************
    reg [ADDR_W-1:0] aw_addr_reg;
    reg              aw_held_reg;
    reg [31:0]       w_data_reg;
    reg              w_lane0_reg;
    reg              w_held_reg;
    wire             wr_fire = aw_held_reg & w_held_reg & ~s_axi_bvalid;
    wire             wr_en   = wr_fire & w_lane0_reg;
    wire [7:0]       wbyte   = w_data_reg[7:0];
    reg              wr_hit;

    always @* begin
        wr_hit = 1'b1;
        if (addr_is(aw_addr_reg, `EIU_OFS_SENSE_CTRL)) begin
        end else if (addr_is(aw_addr_reg, `EIU_OFS_DED_MASK)) begin
        end else if (addr_is(aw_addr_reg, `EIU_OFS_DED_FLAGS)) begin
        end else if (addr_is(aw_addr_reg, `EIU_OFS_GRP_ENABLE)) begin
        end else if (addr_is(aw_addr_reg, `EIU_OFS_GRP_FLAGS)) begin
        end else if (aw_addr_reg[7:2] >= `EIU_OFS_CHG_MASK0 >> 2 &&
                     aw_addr_reg[7:2] <= `EIU_OFS_CHG_MASK3 >> 2) begin
        end else if (addr_is(aw_addr_reg, `EIU_OFS_GLOBAL_CTRL)) begin
        end else if (addr_is(aw_addr_reg, `EIU_OFS_PIN_STATUS)) begin
        end else begin
            wr_hit = 1'b0;
        end
    end

    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            aw_addr_reg   <= {ADDR_W{1'b0}};
            aw_held_reg   <= 1'b0;
            w_data_reg    <= 32'h0000_0000;
            w_lane0_reg   <= 1'b0;
            w_held_reg    <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `EIU_RESP_OKAY;
        end else begin
            s_axi_awready <= ~aw_held_reg & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready  <= ~w_held_reg & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid & s_axi_awready) begin
                aw_addr_reg <= s_axi_awaddr;
                aw_held_reg <= 1'b1;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_data_reg  <= s_axi_wdata;
                w_lane0_reg <= s_axi_wstrb[0];
                w_held_reg  <= 1'b1;
            end
            if (wr_fire) begin
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `EIU_RESP_OKAY : `EIU_RESP_SLVERR;
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // control registers and pending flags
    // ****************************************************************
    wire wr_ded_flags = wr_en & addr_is(aw_addr_reg, `EIU_OFS_DED_FLAGS);
    wire wr_grp_flags = wr_en & addr_is(aw_addr_reg, `EIU_OFS_GRP_FLAGS);

    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            ext_int_sense_control_reg <= `EIU_SENSE_RST;
            dedicated_irq_mask_reg    <= `EIU_DED_MASK_RST;
            grp_enable_reg            <= `EIU_GRP_ENABLE_RST;
            change_mask_reg           <= {4{`EIU_CHG_MASK_RST}};
            global_irq_enable_reg     <= `EIU_GIE_RST;
            ded_flags_reg             <= 3'h0;
            grp_flags_reg             <= 4'h0;
        end else begin
            if (wr_en) begin
                if (addr_is(aw_addr_reg, `EIU_OFS_SENSE_CTRL)) begin
                    ext_int_sense_control_reg <= wbyte[5:0];
                end else if (addr_is(aw_addr_reg, `EIU_OFS_DED_MASK)) begin
                    dedicated_irq_mask_reg <= wbyte[2:0];
                end else if (addr_is(aw_addr_reg, `EIU_OFS_GRP_ENABLE)) begin
                    grp_enable_reg <= wbyte[3:0];
                end else if (addr_is(aw_addr_reg, `EIU_OFS_CHG_MASK0)) begin
                    change_mask_reg[7:0] <= wbyte;
                end else if (addr_is(aw_addr_reg, `EIU_OFS_CHG_MASK1)) begin
                    change_mask_reg[15:8] <= wbyte;
                end else if (addr_is(aw_addr_reg, `EIU_OFS_CHG_MASK2)) begin
                    change_mask_reg[23:16] <= wbyte;
                end else if (addr_is(aw_addr_reg, `EIU_OFS_CHG_MASK3)) begin
                    change_mask_reg[31:24] <= wbyte;
                end else if (addr_is(aw_addr_reg, `EIU_OFS_GLOBAL_CTRL)) begin
                    global_irq_enable_reg <= wbyte[`EIU_GIE_BIT];
                end
            end
            // write-one-to-clear or core acknowledge; a new event wins
            ded_flags_reg <= (ded_flags_reg &
                              ~(ded_ack_i | (wr_ded_flags ? wbyte[2:0] : 3'h0)))
                             | ded_edge;
            grp_flags_reg <= (grp_flags_reg &
                              ~(grp_ack_i | (wr_grp_flags ? wbyte[3:0] : 4'h0)))
                             | grp_hit;
        end
    end

    // ****************************************************************
    // wake and start-up
    // ****************************************************************
    // level requests are held back until start-up ends; a level that is
    // gone by then woke the part but raises nothing
    wire wake_cause = |(ded_flags_reg & dedicated_irq_mask_reg) |
                      |(ded_level & dedicated_irq_mask_reg) |
                      |(grp_flags_reg & grp_enable_reg);
    wire startup_done = (startup_cnt_reg == 16'h0000) & ~(sleep_d_reg & ~sleep_i);

    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            sleep_d_reg     <= 1'b0;
            startup_cnt_reg <= 16'h0000;
            wake_o          <= 1'b0;
        end else begin
            sleep_d_reg <= sleep_i;
            wake_o      <= sleep_i & wake_cause;
            if (sleep_d_reg & ~sleep_i) begin
                startup_cnt_reg <= STARTUP_CYC;
            end else if (~sleep_i & ~startup_done) begin
                startup_cnt_reg <= startup_cnt_reg - 16'h0001;
            end
        end
    end

    // ****************************************************************
    // requests to the core
    // ****************************************************************
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            dedicated_irq_o    <= 3'h0;
            change_group_irq_o <= 4'h0;
        end else begin
            dedicated_irq_o <= {3{global_irq_enable_reg & ~sleep_i}} &
                               dedicated_irq_mask_reg &
                               (ded_flags_reg |
                                (ded_level & {3{startup_done}}));
            change_group_irq_o <= {4{global_irq_enable_reg & ~sleep_i}} &
                                  grp_enable_reg & grp_flags_reg;
        end
    end

    // ****************************************************************
    // axi4-lite read channel
    // ****************************************************************
    reg [31:0] rd_data;
    reg        rd_hit;

    always @* begin
        rd_data = 32'h0000_0000;
        rd_hit  = 1'b1;
        if (addr_is(s_axi_araddr, `EIU_OFS_SENSE_CTRL)) begin
            rd_data[7:0] = {2'b00, ext_int_sense_control_reg};
        end else if (addr_is(s_axi_araddr, `EIU_OFS_DED_MASK)) begin
            rd_data[2:0] = dedicated_irq_mask_reg;
        end else if (addr_is(s_axi_araddr, `EIU_OFS_DED_FLAGS)) begin
            rd_data[2:0] = ded_flags_reg;
        end else if (addr_is(s_axi_araddr, `EIU_OFS_GRP_ENABLE)) begin
            rd_data[3:0] = grp_enable_reg;
        end else if (addr_is(s_axi_araddr, `EIU_OFS_GRP_FLAGS)) begin
            rd_data[3:0] = grp_flags_reg;
        end else if (addr_is(s_axi_araddr, `EIU_OFS_CHG_MASK0)) begin
            rd_data[7:0] = change_mask_reg[7:0];
        end else if (addr_is(s_axi_araddr, `EIU_OFS_CHG_MASK1)) begin
            rd_data[7:0] = change_mask_reg[15:8];
        end else if (addr_is(s_axi_araddr, `EIU_OFS_CHG_MASK2)) begin
            rd_data[7:0] = change_mask_reg[23:16];
        end else if (addr_is(s_axi_araddr, `EIU_OFS_CHG_MASK3)) begin
            rd_data[7:0] = change_mask_reg[31:24];
        end else if (addr_is(s_axi_araddr, `EIU_OFS_GLOBAL_CTRL)) begin
            rd_data[`EIU_GIE_BIT] = global_irq_enable_reg;
        end else if (addr_is(s_axi_araddr, `EIU_OFS_PIN_STATUS)) begin
            // synchronised levels, so reads lag the pads by two clocks
            rd_data = {chg_s2_reg[28:0], ded_s2_reg};
        end else begin
            rd_hit = 1'b0;
        end
    end

    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `EIU_RESP_OKAY;
        end else begin
            s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_data;
                s_axi_rresp  <= rd_hit ? `EIU_RESP_OKAY : `EIU_RESP_SLVERR;
            end else if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // eiu_top

`default_nettype wire

// [tb/eiu_monitor.sv]
// Purpose: port-level checks of the external interrupt unit
// Assumes: one clock, synchronous active-high reset
// Notes:   attached by bind from the bench top file
`timescale 1ns/1ps
`default_nettype none
module eiu_monitor (
    input wire logic        clk_sys_i,
    input wire logic        rst_i,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        sleep_i,
    input wire logic [2:0]  dedicated_irq_o,
    input wire logic [3:0]  change_group_irq_o,
    input wire logic        wake_o
);
    // ****************************************************************
    // sequences and assertions
    // ****************************************************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    AST_WR_LAT: assert property (s_wr_taken |=> ##1 s_axi_bvalid)
        else $error("write response not two cycles after handshake");
    AST_RD_LAT: assert property (s_rd_taken |=> s_axi_rvalid)
        else $error("read data not one cycle after handshake");
    AST_B_DROP: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    AST_R_DROP: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data repeated");
    AST_AR_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
    AST_AW_PULSE: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("write address ready held");
    AST_SLEEP_GATE: assert property (sleep_i && $past(sleep_i) |-> dedicated_irq_o == 3'h0 && change_group_irq_o == 4'h0)
        else $error("request to core while asleep");
    AST_WAKE: assert property (!$past(sleep_i) |-> !wake_o)
        else $error("wake without sleep");
endmodule // eiu_monitor
`default_nettype wire

// [tb/eiu_pads.sv]
// Purpose: off-chip pad drivers of the dedicated and pin-change lines
// Assumes: bench commands levels; slow_i adds three cycles of board delay
// Notes:   levels are held for many cycles, never as narrow glitches
`timescale 1ns/1ps
`default_nettype none
module eiu_pads (
    input  wire logic        clk_sys_i,
    input  wire logic        slow_i,
    input  wire logic [2:0]  ded_lvl_i,
    input  wire logic [31:0] chg_lvl_i,
    output wire logic [2:0]  ded_pins_o,
    output wire logic [31:0] chg_pins_o
);
    logic [34:0] dly_reg [0:2];
    always @(posedge clk_sys_i) begin
        dly_reg[0] <= {ded_lvl_i, chg_lvl_i};
        dly_reg[1] <= dly_reg[0];
        dly_reg[2] <= dly_reg[1];
    end
    // pins read back whatever drives them, port outputs included
    // each level stands far longer than the minimum pulse width
    assign {ded_pins_o, chg_pins_o} = slow_i ? dly_reg[2] : {ded_lvl_i, chg_lvl_i};
endmodule // eiu_pads
`default_nettype wire

// [tb/testbench.sv]
// Purpose: self-checking bench of the external interrupt unit
// Assumes: short start-up count so wake sequences stay brief
// Notes:   reads are checked from a queue by a watcher process
`timescale 1ns/1ps
`include "eiu_map.vh"
`default_nettype none
module testbench;
    localparam int SU = 4;
    logic        clk_sys_i = 1'b0, rst_i = 1'b1, sleep_i = 1'b0, slow = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0, chg_lvl = 32'h0, rnd;
    logic [3:0]  s_axi_wstrb = 4'h0, grp_ack_i = 4'h0;
    logic [2:0]  ded_lvl = 3'h7, ded_ack_i = 3'h0;
    wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, wake_o;
    wire logic [1:0]  s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata, pin_change_inputs_i;
    wire logic [2:0]  dedicated_irq_pins_i, dedicated_irq_o;
    wire logic [3:0]  change_group_irq_o;
    integer      seed = 32'h96b5387c;
    int          num_errors = 0, compares = 0, cyc = 0, g, m, b;
    logic [33:0] rq[$];

    initial forever #5 clk_sys_i = ~clk_sys_i;
    eiu_top #(.ADDR_W(8), .STARTUP_CYC(16'd4)) DUT (.*);
    eiu_pads u_pads (.clk_sys_i(clk_sys_i), .slow_i(slow), .ded_lvl_i(ded_lvl),
        .chg_lvl_i(chg_lvl), .ded_pins_o(dedicated_irq_pins_i), .chg_pins_o(pin_change_inputs_i));

    // ****************************************************************
    // checking and bus tasks
    // ****************************************************************
    task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic stop_test;
        $display("counts: %0d compares, %0d mismatches", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic cyc_n(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ga, gw;
        ga = 1'b0;
        gw = 1'b0;
        @(posedge clk_sys_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        // upper lanes random: only lane 0 may matter
        s_axi_wstrb <= 4'($random(seed)) | 4'h1;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(ga && gw)) begin
            @(posedge clk_sys_i);
            if (s_axi_awready) ga = 1'b1;
            if (s_axi_wready) gw = 1'b1;
            if (ga) s_axi_awvalid <= 1'b0;
            if (gw) s_axi_wvalid <= 1'b0;
        end
        do @(posedge clk_sys_i); while (!s_axi_bvalid);
        chk("bresp", {32'h0, s_axi_bresp}, {32'h0, er});
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        rq.push_back(e);
        @(posedge clk_sys_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk_sys_i); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk_sys_i); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask
    always @(posedge clk_sys_i) begin
        if (s_axi_rvalid && s_axi_rready) chk("read", {s_axi_rresp, s_axi_rdata}, rq.pop_front());
    end
    // eight cycles cover sync, flag and request stages plus slow pads
    task automatic drive(input logic [2:0] d, input logic [31:0] c);
        @(posedge clk_sys_i);
        ded_lvl <= d;
        chg_lvl <= c;
        cyc_n(8);
    endtask
    task automatic see(input logic [2:0] d, input logic [3:0] gv, input logic w);
        chk("irq", {26'h0, dedicated_irq_o, change_group_irq_o, wake_o}, {26'h0, d, gv, w});
    endtask
    task automatic clr;
        @(posedge clk_sys_i);
        ded_ack_i <= 3'h7;
        grp_ack_i <= 4'hf;
        @(posedge clk_sys_i);
        ded_ack_i <= 3'h0;
        grp_ack_i <= 4'h0;
        cyc_n(3);
    endtask
    task automatic nap(input logic s);
        @(posedge clk_sys_i);
        sleep_i <= s;
    endtask
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            num_errors++;
            stop_test();
        end
    end

    // ****************************************************************
    // scenarios
    // ****************************************************************
    initial begin
        cyc_n(8);
        rst_i <= 1'b0;
        rd(`EIU_OFS_SENSE_CTRL, 34'h0);
        rd(`EIU_OFS_GLOBAL_CTRL, 34'h0);
        rd(8'h2c, {`EIU_RESP_SLVERR, 32'h0});
        rd(`EIU_OFS_PIN_STATUS, {2'b00, 29'h0, 3'h7});
        wr(8'h2c, 32'hff, `EIU_RESP_SLVERR);
        rnd = $random(seed);
        wr(`EIU_OFS_SENSE_CTRL, rnd | 32'hc0, `EIU_RESP_OKAY);
        rd(`EIU_OFS_SENSE_CTRL, {28'h0, rnd[5:0]});
        $display("test registers done");
        wr(`EIU_OFS_GLOBAL_CTRL, 32'h1, `EIU_RESP_OKAY);
        wr(`EIU_OFS_GRP_ENABLE, 32'hf, `EIU_RESP_OKAY);
        for (g = 0; g < 4; g++) begin
            clr();
            slow <= g[0];
            b = {$random(seed)} % 8;
            wr(`EIU_OFS_CHG_MASK0 + 8'(4 * g), 32'h1 << b, `EIU_RESP_OKAY);
            drive(3'h7, 32'h1 << (8 * g + (b + 1) % 8));
            see(3'h0, 4'h0, 1'b0);
            drive(3'h7, chg_lvl ^ (32'h1 << (8 * g + b)));
            see(3'h0, 4'h1 << g, 1'b0);
            rd(`EIU_OFS_GRP_FLAGS, {30'h0, 4'h1 << g});
            drive(3'h7, 32'h0);
            see(3'h0, 4'h1 << g, 1'b0);
            clr();
            see(3'h0, 4'h0, 1'b0);
        end
        $display("test change groups done");
        wr(`EIU_OFS_DED_MASK, 32'h7, `EIU_RESP_OKAY);
        for (m = 0; m < 4; m++) begin
            wr(`EIU_OFS_SENSE_CTRL, 32'(m), `EIU_RESP_OKAY);
            clr();
            drive(3'h6, 32'h0);
            see({2'b00, m != 3}, 4'h0, 1'b0);
            drive(3'h7, 32'h0);
            see({2'b00, m != 0}, 4'h0, 1'b0);
        end
        wr(`EIU_OFS_SENSE_CTRL, 32'h2, `EIU_RESP_OKAY);
        clr();
        wr(`EIU_OFS_GLOBAL_CTRL, 32'h0, `EIU_RESP_OKAY);
        drive(3'h6, 32'h0);
        see(3'h0, 4'h0, 1'b0);
        wr(`EIU_OFS_GLOBAL_CTRL, 32'h1, `EIU_RESP_OKAY);
        cyc_n(3);
        see(3'h1, 4'h0, 1'b0);
        wr(`EIU_OFS_DED_FLAGS, 32'h1, `EIU_RESP_OKAY);
        cyc_n(2);
        see(3'h0, 4'h0, 1'b0);
        drive(3'h7, 32'h0);
        clr();
        $display("test dedicated lines done");
        nap(1'b1);
        drive(3'h5, 32'h0);
        see(3'h0, 4'h0, 1'b1);
        // level is released as the part wakes, well before start-up ends
        nap(1'b0);
        ded_lvl <= 3'h7;
        cyc_n(2);
        see(3'h0, 4'h0, 1'b0);
        cyc_n(SU + 8);
        see(3'h0, 4'h0, 1'b0);
        nap(1'b1);
        // source holds the low level across the whole start-up
        drive(3'h5, 32'h0);
        see(3'h0, 4'h0, 1'b1);
        nap(1'b0);
        cyc_n(SU + 8);
        see(3'h2, 4'h0, 1'b0);
        drive(3'h7, 32'h0);
        wr(`EIU_OFS_CHG_MASK0, 32'hff, `EIU_RESP_OKAY);
        nap(1'b1);
        drive(3'h7, 32'h1);
        see(3'h0, 4'h0, 1'b1);
        nap(1'b0);
        cyc_n(3);
        see(3'h0, 4'h1, 1'b0);
        $display("test sleep and wake done");
        stop_test();
    end
endmodule // testbench
bind eiu_top eiu_monitor u_mon (.*);
`default_nettype wire
